// File: design/sysr_pkg.sv
// Purpose: shared constants and types for the system-control id and
//          overflow request register bank
// Assumes: one core clock, coprocessor transfers arrive as one-cycle
//          requests from the pipeline
// Notes:   enables are held as 4 bits {cycle, ev2, ev1, ev0}
package sysr_pkg;

    // coprocessor register coordinates (opc1 is always zero)
    localparam logic [2:0] SYSR_OPC1 = 3'h0;
    localparam logic [3:0] SYSR_CRN_SLAVE = 4'hb;
    localparam logic [3:0] SYSR_CRN_ID = 4'hd;
    localparam logic [3:0] SYSR_CRN_VAL = 4'hf;
    localparam logic [3:0] SYSR_CRM_SLAVE = 4'h0;
    localparam logic [3:0] SYSR_CRM_ID = 4'h0;
    localparam logic [3:0] SYSR_CRM_VAL = 4'h1;
    localparam logic [2:0] SYSR_OP2_SLAVE = 3'h0;
    localparam logic [2:0] SYSR_OP2_LPID = 3'h0;
    localparam logic [2:0] SYSR_OP2_CTX = 3'h1;
    localparam logic [2:0] SYSR_OP2_TID_URW = 3'h2;
    localparam logic [2:0] SYSR_OP2_TID_URO = 3'h3;
    localparam logic [2:0] SYSR_OP2_TID_PRV = 3'h4;
    localparam logic [2:0] SYSR_OP2_IRQ_SET = 3'h0;
    localparam logic [2:0] SYSR_OP2_FIQ_SET = 3'h1;
    localparam logic [2:0] SYSR_OP2_RST_SET = 3'h2;
    localparam logic [2:0] SYSR_OP2_IRQ_CLR = 3'h4;
    localparam logic [2:0] SYSR_OP2_FIQ_CLR = 3'h5;
    localparam logic [2:0] SYSR_OP2_RST_CLR = 3'h6;

    // field positions
    localparam int SYSR_SLAVE_PRIV_BIT = 1;
    localparam int SYSR_SLAVE_DIS_BIT = 0;
    localparam int SYSR_EN_CYCLE_BIT = 31;

    // reset values
    localparam logic [1:0] SYSR_SLAVE_RST = 2'h0;
    localparam logic [31:0] SYSR_WORD_RST = 32'h0000_0000;
    localparam logic [3:0] SYSR_EN_RST = 4'h0;
    localparam logic SYSR_REQ_N_RST = 1'b1;

    typedef enum {
        SYSR_R_NONE, SYSR_R_SLAVE, SYSR_R_LPID, SYSR_R_CTX,
        SYSR_R_TID_URW, SYSR_R_TID_URO, SYSR_R_TID_PRV,
        SYSR_R_IRQ_SET, SYSR_R_FIQ_SET, SYSR_R_RST_SET,
        SYSR_R_IRQ_CLR, SYSR_R_FIQ_CLR, SYSR_R_RST_CLR
    } sysr_reg_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic priv;
        logic [2:0] opc1;
        logic [3:0] crn;
        logic [3:0] crm;
        logic [2:0] opc2;
        logic [31:0] wdata;
    } sysr_req_s;

    typedef struct packed {
        logic valid;
        logic undef;
        logic [31:0] rdata;
    } sysr_rsp_s;

endpackage

// File: design/sysr_ovf_req.sv
// Purpose: one overflow request channel: set/clear enables and the
//          active-low request output
// Assumes: set and clear writes never arrive in the same cycle
// Notes:   enables are {cycle, ev2, ev1, ev0}
`timescale 1ns/10ps
module sysr_ovf_req
    import sysr_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic set_we,
    input wire logic clr_we,
    input wire logic [3:0] wbits,
    input wire logic [3:0] overflow,
    output logic [3:0] enables,
    output logic req_n
);

    logic [3:0] en_q;
    logic req_n_q;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            en_q <= SYSR_EN_RST;
        end else if (set_we) begin
            en_q <= en_q | wbits;
        end else if (clr_we) begin
            en_q <= en_q & ~wbits;
        end
    end

    // registered so the controller never sees a decode glitch
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            req_n_q <= SYSR_REQ_N_RST;
        end else begin
            req_n_q <= ~|(overflow & en_q);
        end
    end

    assign enables = en_q;
    assign req_n = req_n_q;

    a_set_only_sets: assert property (
        @(posedge mclk) disable iff (!nrst)
        set_we |=> en_q == ($past(en_q) | $past(wbits)))
        else $error("set write did not only set enables");
    a_clr_only_clears: assert property (
        @(posedge mclk) disable iff (!nrst)
        clr_we && !set_we |=> en_q == ($past(en_q) & ~$past(wbits)))
        else $error("clear write wrong");
    a_req_follows_en: assert property (
        @(posedge mclk) disable iff (!nrst)
        ##1 req_n == !(|($past(overflow) & $past(en_q))))
        else $error("request output does not follow enabled overflow");

endmodule

// File: design/sysr_regs.sv
// Purpose: id registers, slave port control and overflow request
//          enables reached by coprocessor register transfers
// Assumes: overflow flags and the user enable come from logic on mclk
// Notes:   a transfer is answered one cycle after it is taken
//
// Functional notes
// - slave control bit 1 restricts to privileged
// - slave control bit 0 disables slave port
// - legacy process id reads zero, ignores writes
// - context identifier 32 bits, privileged only
// - context identifier driven to trace and debug
// - user rw thread id open to all
// - user ro thread id: user reads only
// - privileged thread id refuses user access
// - thread id access has no side effects
// - thread id registers reset to zero
// - irq enables at bits 31, 2..0
// - set register reads enables, writes set
// - enabled overflow drives irq request low
// - fiq enables share the irq layout
// - enabled overflow drives fiq request low
// - enabled overflow drives reset request low
// - user access to enables needs user enable
// - reset enables at bits 31, 2..0
// - clear register reads enables, ones clear
`timescale 1ns/10ps
module sysr_regs
    import sysr_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input sysr_req_s cp_req,
    output sysr_rsp_s cp_rsp,
    input wire logic [3:0] counter_overflow,
    input wire logic perfmon_user_access_enable,
    output logic slave_port_privileged_only,
    output logic slave_port_disable,
    output logic [31:0] context_identifier,
    output logic overflow_irq_req_n,
    output logic overflow_fiq_req_n,
    output logic overflow_reset_req_out_n
);

    function automatic sysr_reg_e sysr_decode(input sysr_req_s r);
        sysr_reg_e sel;
        sel = SYSR_R_NONE;
        if (r.opc1 == SYSR_OPC1) begin
            if (r.crn == SYSR_CRN_SLAVE && r.crm == SYSR_CRM_SLAVE &&
                r.opc2 == SYSR_OP2_SLAVE) begin
                sel = SYSR_R_SLAVE;
            end else if (r.crn == SYSR_CRN_ID && r.crm == SYSR_CRM_ID) begin
                case (r.opc2)
                    SYSR_OP2_LPID: sel = SYSR_R_LPID;
                    SYSR_OP2_CTX: sel = SYSR_R_CTX;
                    SYSR_OP2_TID_URW: sel = SYSR_R_TID_URW;
                    SYSR_OP2_TID_URO: sel = SYSR_R_TID_URO;
                    SYSR_OP2_TID_PRV: sel = SYSR_R_TID_PRV;
                    default: sel = SYSR_R_NONE;
                endcase
            end else if (r.crn == SYSR_CRN_VAL && r.crm == SYSR_CRM_VAL) begin
                case (r.opc2)
                    SYSR_OP2_IRQ_SET: sel = SYSR_R_IRQ_SET;
                    SYSR_OP2_FIQ_SET: sel = SYSR_R_FIQ_SET;
                    SYSR_OP2_RST_SET: sel = SYSR_R_RST_SET;
                    SYSR_OP2_IRQ_CLR: sel = SYSR_R_IRQ_CLR;
                    SYSR_OP2_FIQ_CLR: sel = SYSR_R_FIQ_CLR;
                    SYSR_OP2_RST_CLR: sel = SYSR_R_RST_CLR;
                    default: sel = SYSR_R_NONE;
                endcase
            end
        end
        return sel;
    endfunction

    // mode check; a refused access is answered undefined and has no effect
    function automatic logic sysr_allowed(input sysr_reg_e sel,
                                          input logic wr,
                                          input logic priv,
                                          input logic usr_en);
        logic ok;
        ok = 1'b0;
        case (sel)
            SYSR_R_NONE: ok = 1'b0;
            SYSR_R_TID_URW: ok = 1'b1;
            SYSR_R_TID_URO: ok = priv || !wr;
            SYSR_R_SLAVE, SYSR_R_LPID, SYSR_R_CTX,
            SYSR_R_TID_PRV: ok = priv;
            default: ok = priv || usr_en;
        endcase
        return ok;
    endfunction

    // enable layout is shared by every validation register
    function automatic logic [31:0] sysr_en_word(input logic [3:0] en);
        return {en[3], 28'h000_0000, en[2:0]};
    endfunction

    function automatic logic [3:0] sysr_word_en(input logic [31:0] w);
        return {w[SYSR_EN_CYCLE_BIT], w[2:0]};
    endfunction

    sysr_reg_e sel;
    logic ok;
    logic wr_ok;
    logic [3:0] wbits;
    logic [1:0] slave_q;
    logic [31:0] ctx_q;
    logic [31:0] tid_urw_q;
    logic [31:0] tid_uro_q;
    logic [31:0] tid_prv_q;
    logic [3:0] irq_en;
    logic [3:0] fiq_en;
    logic [3:0] rst_en;
    logic [31:0] rdata_d;
    sysr_rsp_s rsp_q;

    assign sel = sysr_decode(cp_req);
    assign ok = sysr_allowed(sel, cp_req.write, cp_req.priv,
                             perfmon_user_access_enable);
    assign wr_ok = cp_req.valid && cp_req.write && ok;
    assign wbits = sysr_word_en(cp_req.wdata);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            slave_q <= SYSR_SLAVE_RST;
        end else if (wr_ok && sel == SYSR_R_SLAVE) begin
            slave_q <= cp_req.wdata[1:0];
        end
    end

    // zero at reset keeps trace matching quiet until the first write
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctx_q <= SYSR_WORD_RST;
        end else if (wr_ok && sel == SYSR_R_CTX) begin
            ctx_q <= cp_req.wdata;
        end
    end

    // thread ids are plain storage, nothing else reads them
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tid_urw_q <= SYSR_WORD_RST;
            tid_uro_q <= SYSR_WORD_RST;
            tid_prv_q <= SYSR_WORD_RST;
        end else if (wr_ok) begin
            case (sel)
                SYSR_R_TID_URW: tid_urw_q <= cp_req.wdata;
                SYSR_R_TID_URO: tid_uro_q <= cp_req.wdata;
                SYSR_R_TID_PRV: tid_prv_q <= cp_req.wdata;
                default: tid_urw_q <= tid_urw_q;
            endcase
        end
    end

    sysr_ovf_req u_irq (
        .mclk(mclk),
        .nrst(nrst),
        .set_we(wr_ok && sel == SYSR_R_IRQ_SET),
        .clr_we(wr_ok && sel == SYSR_R_IRQ_CLR),
        .wbits(wbits),
        .overflow(counter_overflow),
        .enables(irq_en),
        .req_n(overflow_irq_req_n)
    );

    sysr_ovf_req u_fiq (
        .mclk(mclk),
        .nrst(nrst),
        .set_we(wr_ok && sel == SYSR_R_FIQ_SET),
        .clr_we(wr_ok && sel == SYSR_R_FIQ_CLR),
        .wbits(wbits),
        .overflow(counter_overflow),
        .enables(fiq_en),
        .req_n(overflow_fiq_req_n)
    );

    sysr_ovf_req u_rst (
        .mclk(mclk),
        .nrst(nrst),
        .set_we(wr_ok && sel == SYSR_R_RST_SET),
        .clr_we(wr_ok && sel == SYSR_R_RST_CLR),
        .wbits(wbits),
        .overflow(counter_overflow),
        .enables(rst_en),
        .req_n(overflow_reset_req_out_n)
    );

    always_comb begin
        rdata_d = SYSR_WORD_RST;
        case (sel)
            SYSR_R_SLAVE: rdata_d = {30'h0000_0000, slave_q};
            SYSR_R_LPID: rdata_d = SYSR_WORD_RST;
            SYSR_R_CTX: rdata_d = ctx_q;
            SYSR_R_TID_URW: rdata_d = tid_urw_q;
            SYSR_R_TID_URO: rdata_d = tid_uro_q;
            SYSR_R_TID_PRV: rdata_d = tid_prv_q;
            SYSR_R_IRQ_SET,
            SYSR_R_IRQ_CLR: rdata_d = sysr_en_word(irq_en);
            SYSR_R_FIQ_SET,
            SYSR_R_FIQ_CLR: rdata_d = sysr_en_word(fiq_en);
            SYSR_R_RST_SET,
            SYSR_R_RST_CLR: rdata_d = sysr_en_word(rst_en);
            default: rdata_d = SYSR_WORD_RST;
        endcase
    end

    // write answers return zero data; refused reads never leak contents
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rsp_q <= '0;
        end else begin
            rsp_q.valid <= cp_req.valid;
            rsp_q.undef <= cp_req.valid && !ok;
            if (cp_req.valid && ok && !cp_req.write) begin
                rsp_q.rdata <= rdata_d;
            end else begin
                rsp_q.rdata <= SYSR_WORD_RST;
            end
        end
    end

    assign cp_rsp = rsp_q;
    assign slave_port_privileged_only = slave_q[SYSR_SLAVE_PRIV_BIT];
    assign slave_port_disable = slave_q[SYSR_SLAVE_DIS_BIT];
    assign context_identifier = ctx_q;

    // checks
    logic read_ok;
    assign read_ok = cp_req.valid && ok && !cp_req.write;

    a_slave_priv_bit: assert property (
        @(posedge mclk) disable iff (!nrst)
        wr_ok && sel == SYSR_R_SLAVE |=>
        slave_port_privileged_only == $past(cp_req.wdata[1]))
        else $error("privileged-only bit not taken from write");
    a_slave_dis_bit: assert property (
        @(posedge mclk) disable iff (!nrst)
        wr_ok && sel == SYSR_R_SLAVE |=>
        slave_port_disable == $past(cp_req.wdata[0]))
        else $error("slave disable bit not taken from write");
    a_legacy_pid_zero: assert property (
        @(posedge mclk) disable iff (!nrst)
        cp_req.valid && sel == SYSR_R_LPID && cp_req.priv |=>
        !cp_rsp.undef && cp_rsp.rdata == 32'h0000_0000)
        else $error("legacy process id did not read zero");
    a_ctx_user_refused: assert property (
        @(posedge mclk) disable iff (!nrst)
        cp_req.valid && sel == SYSR_R_CTX && !cp_req.priv |=>
        cp_rsp.undef && $stable(context_identifier))
        else $error("user access to context id not refused");
    a_ctx_read_back: assert property (
        @(posedge mclk) disable iff (!nrst)
        read_ok && sel == SYSR_R_CTX |=> cp_rsp.rdata == $past(ctx_q))
        else $error("context id read returned a wrong value");
    a_ctx_to_trace: assert property (
        @(posedge mclk) disable iff (!nrst)
        wr_ok && sel == SYSR_R_CTX |=>
        context_identifier == $past(cp_req.wdata))
        else $error("context id output not updated");
    a_tid_user_rw: assert property (
        @(posedge mclk) disable iff (!nrst)
        cp_req.valid && sel == SYSR_R_TID_URW |=> !cp_rsp.undef)
        else $error("user rw thread id refused");
    a_tid_uro_write: assert property (
        @(posedge mclk) disable iff (!nrst)
        cp_req.valid && cp_req.write && !cp_req.priv &&
        sel == SYSR_R_TID_URO |=> cp_rsp.undef && $stable(tid_uro_q))
        else $error("user write to ro thread id accepted");
    a_tid_uro_read: assert property (
        @(posedge mclk) disable iff (!nrst)
        cp_req.valid && !cp_req.write && sel == SYSR_R_TID_URO |=>
        !cp_rsp.undef && cp_rsp.rdata == $past(tid_uro_q))
        else $error("read of ro thread id refused or wrong");
    a_tid_prv_user: assert property (
        @(posedge mclk) disable iff (!nrst)
        cp_req.valid && !cp_req.priv && sel == SYSR_R_TID_PRV |=>
        cp_rsp.undef && $stable(tid_prv_q))
        else $error("user access to privileged thread id accepted");
    a_tid_no_side: assert property (
        @(posedge mclk) disable iff (!nrst)
        cp_req.valid && (sel == SYSR_R_TID_URW || sel == SYSR_R_TID_URO ||
        sel == SYSR_R_TID_PRV) |=> $stable(slave_q) && $stable(ctx_q) &&
        $stable(irq_en) && $stable(fiq_en) && $stable(rst_en))
        else $error("thread id access changed other state");
    a_val_user_gate: assert property (
        @(posedge mclk) disable iff (!nrst)
        cp_req.valid && !cp_req.priv && !perfmon_user_access_enable &&
        sel >= SYSR_R_IRQ_SET |=> cp_rsp.undef)
        else $error("user access to enables not gated");
    a_val_granted: assert property (
        @(posedge mclk) disable iff (!nrst)
        cp_req.valid && (cp_req.priv || perfmon_user_access_enable) &&
        sel >= SYSR_R_IRQ_SET |=> !cp_rsp.undef)
        else $error("granted access to enables refused");
    a_irq_layout: assert property (
        @(posedge mclk) disable iff (!nrst)
        read_ok && sel == SYSR_R_IRQ_SET |=>
        cp_rsp.rdata[30:3] == 28'h000_0000 &&
        cp_rsp.rdata[31] == $past(irq_en[3]))
        else $error("irq enable layout wrong");
    a_fiq_layout: assert property (
        @(posedge mclk) disable iff (!nrst)
        read_ok && sel == SYSR_R_FIQ_SET |=>
        cp_rsp.rdata[30:3] == 28'h000_0000 &&
        cp_rsp.rdata[31] == $past(fiq_en[3]))
        else $error("fiq enable layout wrong");
    a_rst_layout: assert property (
        @(posedge mclk) disable iff (!nrst)
        read_ok && sel == SYSR_R_RST_SET |=>
        cp_rsp.rdata[30:3] == 28'h000_0000 &&
        cp_rsp.rdata[2:0] == $past(rst_en[2:0]))
        else $error("reset enable layout wrong");
    a_clr_reads_en: assert property (
        @(posedge mclk) disable iff (!nrst)
        read_ok && sel == SYSR_R_IRQ_CLR |=>
        cp_rsp.rdata[31] == $past(irq_en[3]) &&
        cp_rsp.rdata[2:0] == $past(irq_en[2:0]))
        else $error("clear register read is not the enables");
    a_irq_request: assert property (
        @(posedge mclk) disable iff (!nrst)
        (|(counter_overflow & irq_en)) ##1 (|(counter_overflow & irq_en))
        |-> !overflow_irq_req_n)
        else $error("enabled overflow did not raise irq request");
    a_fiq_request: assert property (
        @(posedge mclk) disable iff (!nrst)
        ##1 overflow_fiq_req_n ==
        !(|($past(counter_overflow) & $past(fiq_en))))
        else $error("fiq request wrong");
    a_rst_request: assert property (
        @(posedge mclk) disable iff (!nrst)
        !(|(counter_overflow & rst_en)) |=> overflow_reset_req_out_n)
        else $error("reset request without enabled overflow");
    a_rst_asserted: assert property (
        @(posedge mclk) disable iff (!nrst)
        (|(counter_overflow & rst_en)) |=> !overflow_reset_req_out_n)
        else $error("enabled overflow did not raise reset request");

    c_user_tid_write: cover property (@(posedge mclk) disable iff (!nrst)
        wr_ok && !cp_req.priv && sel == SYSR_R_TID_URW);
    c_irq_raised: cover property (@(posedge mclk) disable iff (!nrst)
        $fell(overflow_irq_req_n));
    c_enable_cleared: cover property (@(posedge mclk) disable iff (!nrst)
        wr_ok && sel == SYSR_R_RST_CLR ##2 $rose(overflow_reset_req_out_n));
    c_refused: cover property (@(posedge mclk) disable iff (!nrst)
        cp_rsp.valid && cp_rsp.undef);

endmodule

// File: tb/sysr_ovf_src.sv
// Purpose: counter-side model feeding level overflow flags to the bank
// Assumes: flags are levels held by the counters, cleared by reset
// Notes:   a new pattern shows one cycle after it is handed over
`timescale 1ns/10ps
module sysr_ovf_src (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [3:0] value,
    output logic [3:0] counter_overflow
);
    logic [3:0] ovf_q;

    // flags move just after the edge, as a real counter bank would
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ovf_q <= 4'h0;
        end else begin
            ovf_q <= value;
        end
    end
    assign counter_overflow = ovf_q;
endmodule

// File: tb/tb.sv
// Purpose: self-checking bench for the id and overflow request bank
// Assumes: one transfer in flight unless a scenario pipelines two
// Notes:   shadow state in the bench predicts every answer
`timescale 1ns/10ps
module tb;
    import sysr_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    sysr_req_s cp_req = '0;
    sysr_rsp_s cp_rsp;
    logic [3:0] ovf_val = 4'h0;
    logic [3:0] counter_overflow;
    logic usr_en = 1'b0;
    logic sp_priv;
    logic sp_dis;
    logic irq_n;
    logic fiq_n;
    logic rst_n;
    logic [31:0] ctx;
    int failures = 0;
    int tests_run = 0;
    logic [15:0] lfsr_q = 16'hea3c;
    logic [1:0] m_slave;
    logic [31:0] m_ctx;
    logic [31:0] m_tid [3];
    logic [3:0] m_en [3];

    always #2.5 mclk = ~mclk;

    sysr_ovf_src i_src (.mclk(mclk), .nrst(nrst), .value(ovf_val),
        .counter_overflow(counter_overflow));
    sysr_regs i_dut (.mclk(mclk), .nrst(nrst), .cp_req(cp_req),
        .cp_rsp(cp_rsp), .counter_overflow(counter_overflow),
        .perfmon_user_access_enable(usr_en),
        .slave_port_privileged_only(sp_priv), .slave_port_disable(sp_dis),
        .context_identifier(ctx), .overflow_irq_req_n(irq_n),
        .overflow_fiq_req_n(fiq_n), .overflow_reset_req_out_n(rst_n));

    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic rnd(output logic [31:0] v);
        lfsr_q = lfsr_next(lfsr_q);
        v[31:16] = lfsr_q;
        lfsr_q = lfsr_next(lfsr_q);
        v[15:0] = lfsr_q;
    endtask

    function automatic logic [31:0] en_word(input logic [3:0] e);
        return {e[3], 28'h000_0000, e[2:0]};
    endfunction

    // class: 0 slave, 1 legacy id, 2 context, 3..5 thread ids,
    // 6..8 enable sets, 9..11 enable clears, -1 unmapped
    function automatic int decode(input logic [2:0] o1,
        input logic [3:0] n, input logic [3:0] m, input logic [2:0] o2);
        if (o1 != 3'h0) return -1;
        if (n == 4'hb && m == 4'h0 && o2 == 3'h0) return 0;
        if (n == 4'hd && m == 4'h0 && o2 <= 3'h4) return 1 + int'(o2);
        if (n == 4'hf && m == 4'h1 && o2 != 3'h3 && o2 != 3'h7)
            return 6 + int'(o2) - int'(o2 > 3'h3);
        return -1;
    endfunction

    function automatic bit allowed(input int c, input logic w,
        input logic p, input logic u);
        if (c < 0) return 0;
        if (c == 3) return 1;
        if (c == 4) return p || !w;
        if (c >= 6) return p || u;
        return p;
    endfunction

    task automatic chk(input string name, input logic [31:0] seen,
        input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, want, seen);
        end
    endtask

    task automatic acc(input logic [2:0] o1, input logic [3:0] n,
        input logic [3:0] m, input logic [2:0] o2, input logic w,
        input logic p, input logic [31:0] d);
        int c;
        bit ok;
        logic [31:0] rd;
        c = decode(o1, n, m, o2);
        @(posedge mclk);
        cp_req <= '{1'b1, w, p, o1, n, m, o2, d};
        ok = allowed(c, w, p, usr_en);
        rd = 32'h0000_0000;
        if (ok && !w) begin
            case (c)
                0: rd = {30'h0000_0000, m_slave};
                2: rd = m_ctx;
                3, 4, 5: rd = m_tid[c-3];
                6, 7, 8: rd = en_word(m_en[c-6]);
                9, 10, 11: rd = en_word(m_en[c-9]);
                default: rd = 32'h0000_0000;
            endcase
        end
        @(posedge mclk);
        cp_req.valid <= 1'b0;
        #1;
        chk("rsp_valid", 32'(cp_rsp.valid), 32'h1);
        chk("rsp_undef", 32'(cp_rsp.undef), 32'(!ok));
        chk("rsp_rdata", cp_rsp.rdata, rd);
        if (ok && w) begin
            case (c)
                0: m_slave = d[1:0];
                2: m_ctx = d;
                3, 4, 5: m_tid[c-3] = d;
                6, 7, 8: m_en[c-6] = m_en[c-6] | {d[31], d[2:0]};
                9, 10, 11: m_en[c-9] = m_en[c-9] & ~{d[31], d[2:0]};
                default: ;
            endcase
        end
        chk("slave_ctl", 32'({sp_priv, sp_dis}), 32'(m_slave));
        chk("context_out", ctx, m_ctx);
    endtask

    task automatic chk_req();
        repeat (2) @(posedge mclk);
        #1;
        chk("irq_n", 32'(irq_n), 32'(~|(counter_overflow & m_en[0])));
        chk("fiq_n", 32'(fiq_n), 32'(~|(counter_overflow & m_en[1])));
        chk("rst_n", 32'(rst_n), 32'(~|(counter_overflow & m_en[2])));
    endtask

    task automatic do_reset();
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        m_slave = 2'h0;
        m_ctx = 32'h0000_0000;
        m_tid = '{default: 32'h0000_0000};
        m_en = '{default: 4'h0};
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #100000;
        failures++;
        end_of_test();
    end

    initial begin
        logic [31:0] v;
        logic [31:0] d;
        logic [3:0] n;
        do_reset();
        // reset values, unmapped holes and a nonzero opc1
        for (int k = 0; k < 8; k++) begin
            acc(3'h0, 4'hd, 4'h0, 3'(k), 1'b0, 1'b1, 32'h0000_0000);
            acc(3'h0, 4'hf, 4'h1, 3'(k), 1'b0, 1'b1, 32'h0000_0000);
        end
        acc(3'h0, 4'hb, 4'h0, 3'h0, 1'b0, 1'b1, 32'h0000_0000);
        acc(3'h1, 4'hd, 4'h0, 3'h1, 1'b0, 1'b1, 32'h0000_0000);
        // reserved enable bits stay zero; clear keeps cycle and event 0
        acc(3'h0, 4'hf, 4'h1, 3'h0, 1'b1, 1'b1, 32'hffff_ffff);
        acc(3'h0, 4'hf, 4'h1, 3'h4, 1'b1, 1'b1, 32'h7fff_fffe);
        acc(3'h0, 4'hf, 4'h1, 3'h0, 1'b0, 1'b1, 32'h0000_0000);
        @(posedge mclk);
        ovf_val <= 4'h1;
        @(posedge mclk);
        #1;
        chk("irq_early", 32'(irq_n), 32'h1);
        @(posedge mclk);
        #1;
        chk("irq_low", 32'(irq_n), 32'h0);
        // a user clear without the user enable must leave the request up
        acc(3'h0, 4'hf, 4'h1, 3'h4, 1'b1, 1'b0, 32'h0000_0001);
        chk_req();
        acc(3'h0, 4'hf, 4'h1, 3'h4, 1'b1, 1'b1, 32'h0000_0001);
        chk_req();
        // back-to-back write then read of the user thread id
        @(posedge mclk);
        cp_req <= '{1'b1, 1'b1, 1'b0, 3'h0, 4'hd, 4'h0, 3'h2, 32'hc0de_5a5a};
        @(posedge mclk);
        cp_req.write <= 1'b0;
        #1;
        chk("b2b_wr", 32'(cp_rsp.valid), 32'h1);
        chk("b2b_undef", 32'(cp_rsp.undef), 32'h0);
        @(posedge mclk);
        cp_req.valid <= 1'b0;
        #1;
        chk("b2b_rd", cp_rsp.rdata, 32'hc0de_5a5a);
        m_tid[0] = 32'hc0de_5a5a;
        for (int i = 0; i < 300; i++) begin
            rnd(v);
            rnd(d);
            @(posedge mclk);
            ovf_val <= v[3:0];
            usr_en <= v[4];
            n = (v[6:5] == 2'h0) ? 4'hb : (v[6:5] == 2'h1) ? 4'hd : 4'hf;
            acc(3'(v[11:8] == 4'h0), n, 4'(n == 4'hf) ^ 4'(v[7] & v[10]),
                v[16:14], v[12], v[13], d);
            chk_req();
        end
        // reset in mid-run clears the thread ids
        do_reset();
        for (int k = 2; k < 5; k++) begin
            acc(3'h0, 4'hd, 4'h0, 3'(k), 1'b0, 1'b1, 32'h0000_0000);
            acc(3'h0, 4'hf, 4'h1, 3'(k - 2), 1'b0, 1'b1, 32'h0);
        end
        chk_req();
        end_of_test();
    end
endmodule
